/* logic/ucp_regs.vh */
// constants and contract list for the utopia slave cell port
// Contract
// - drive outgoing cell bytes on tx link clock
// - rx space flag high when whole cell fits
// - sample rx bus after enable asserted
// - respond on rx side only when addressed
// - strap low ties all cell pins off
// - upper address pins shared with serial port
// - capture rx bytes on rising rx link clock
// - first byte and mark follow tx enable
// - tx cell flag high when cell complete
// - tx mark flags first byte of cell
`ifndef UCP_REGS_VH
`define UCP_REGS_VH
`define UCP_BYTE_W      8
`define UCP_ADDR_W      5
`define UCP_CELL_BYTES  4'h8
`define UCP_CNT_W       4
`define UCP_FIFO_DEPTH  16
`define UCP_FIFO_AW     4
`define UCP_LVL_W       5
`define UCP_STRAP_WAIT  2'h3
`define UCP_SHARED_LO   2
`define UCP_SHARED_W    3
`endif

/* logic/ucp_sync.v */
// two flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ns
module ucp_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clock,
  input  wire         rst,
  // level in and out
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge clock) begin
    if (rst) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* logic/ucp_fifo.v */
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module ucp_fifo #(
  parameter W  = 8,
  parameter D  = 16,
  parameter AW = 4
) (
  // clock and reset
  input  wire          clock,
  input  wire          rst,
  // fill side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  // drain side
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data,
  // fill level
  output reg  [AW:0]   level
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  wire         push;
  wire         pop;

  assign in_ready  = (level != D[AW:0]);
  assign out_valid = (level != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        level <= level + 1'b1;
      end else if (pop & ~push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule

/* logic/ucp_cell_port.v */
// utopia level 2 slave cell port, 8-bit transmit and receive
`timescale 1ns/1ns
`include "ucp_regs.vh"
module ucp_cell_port (
  // clock and reset
  input  wire                    clock,
  input  wire                    rst,
  // strap and own address
  input  wire                    cell_if_strap,
  input  wire [`UCP_ADDR_W-1:0]  rx_own_addr,
  output reg                     cell_if_enable,
  // serial port view of shared address pins
  output reg  [`UCP_SHARED_W-1:0] sp_shared_in,
  // transmit link pins
  input  wire                    tx_link_clk,
  input  wire                    tx_xfer_en_n,
  output reg  [`UCP_BYTE_W-1:0]  tx_cell_byte,
  output wire                    tx_cell_byte_oe,
  output reg                     tx_first_byte_mark,
  output wire                    tx_first_byte_mark_oe,
  output reg                     tx_cell_avail,
  output wire                    tx_cell_avail_oe,
  // receive link pins
  input  wire                    rx_link_clk,
  input  wire                    rx_xfer_en_n,
  input  wire                    rx_first_byte_mark,
  input  wire [`UCP_BYTE_W-1:0]  rx_cell_byte,
  input  wire [`UCP_ADDR_W-1:0]  rx_slave_sel,
  output reg                     rx_space_avail,
  output wire                    rx_space_avail_oe,
  // user transmit byte stream
  input  wire                    tx_in_valid,
  output wire                    tx_in_ready,
  input  wire [`UCP_BYTE_W-1:0]  tx_in_data,
  // user receive byte stream
  output wire                    rx_out_valid,
  input  wire                    rx_out_ready,
  output wire [`UCP_BYTE_W-1:0]  rx_out_data,
  // status
  output reg                     rx_overrun
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for every pin input
  localparam SW = 3 + `UCP_BYTE_W + `UCP_ADDR_W + 3;

  wire [SW-1:0] pins_raw;
  wire [SW-1:0] pins_s;
  reg  [SW-1:0] pins_prev;

  assign pins_raw = {cell_if_strap, tx_link_clk, tx_xfer_en_n,
                     rx_cell_byte, rx_slave_sel,
                     rx_link_clk, rx_xfer_en_n, rx_first_byte_mark};

  ucp_sync #(
    .W (SW)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     (pins_raw),
    .q     (pins_s)
  );

  always @(posedge clock) begin
    if (rst) begin
      pins_prev <= {SW{1'b0}};
    end else begin
      pins_prev <= pins_s;
    end
  end

  wire                   strap_s   = pins_s[SW-1];
  wire                   txclk_s   = pins_s[SW-2];
  wire                   txclk_p   = pins_prev[SW-2];
  wire                   rxclk_s   = pins_s[2];
  wire                   rxclk_p   = pins_prev[2];
  // values seen on the sample just before a detected edge
  wire                   tx_en_n_p = pins_prev[SW-3];
  wire [`UCP_BYTE_W-1:0] rx_byte_p = pins_prev[SW-4 -: `UCP_BYTE_W];
  wire [`UCP_ADDR_W-1:0] rx_sel_p  = pins_prev[7:3];
  wire [`UCP_ADDR_W-1:0] rx_sel_s  = pins_s[7:3];
  wire                   rx_en_n_p = pins_prev[1];
  wire                   rx_soc_p  = pins_prev[0];

  ////////////////////////////////////////////////////////////////////////
  // strap capture after reset release
  reg [1:0] strap_wait;
  wire      strap_take = (strap_wait == `UCP_STRAP_WAIT - 2'h1);

  always @(posedge clock) begin
    if (rst) begin
      strap_wait     <= 2'h0;
      cell_if_enable <= 1'b0;
    end else if (strap_wait != `UCP_STRAP_WAIT) begin
      strap_wait     <= strap_wait + 2'h1;
      if (strap_take) begin
        cell_if_enable <= strap_s;
      end
    end
  end

  // shared pins belong to the serial port unless the port is enabled
  always @(posedge clock) begin
    if (rst) begin
      sp_shared_in <= {`UCP_SHARED_W{1'b0}};
    end else if (cell_if_enable | (strap_take & strap_s)) begin
      sp_shared_in <= {`UCP_SHARED_W{1'b0}};
    end else begin
      sp_shared_in <= rx_sel_s[`UCP_SHARED_LO +: `UCP_SHARED_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link clock edges, ignored while the port is off
  wire tx_edge = cell_if_enable & txclk_s & ~txclk_p;
  wire rx_edge = cell_if_enable & rxclk_s & ~rxclk_p;

  // all pin outputs float while the port is off
  assign tx_cell_byte_oe       = cell_if_enable;
  assign tx_first_byte_mark_oe = cell_if_enable;
  assign tx_cell_avail_oe      = cell_if_enable;

  ////////////////////////////////////////////////////////////////////////
  // transmit buffer
  wire                   txf_valid;
  wire                   txf_pop;
  wire [`UCP_BYTE_W-1:0] txf_data;
  wire [`UCP_LVL_W-1:0]  txf_level;

  ucp_fifo #(
    .W  (`UCP_BYTE_W),
    .D  (`UCP_FIFO_DEPTH),
    .AW (`UCP_FIFO_AW)
  ) u_tx_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .in_data   (tx_in_data),
    .out_valid (txf_valid),
    .out_ready (txf_pop),
    .out_data  (txf_data),
    .level     (txf_level)
  );

  ////////////////////////////////////////////////////////////////////////
  // transmit state machine
  localparam TX_IDLE = 2'b01;
  localparam TX_CELL = 2'b10;

  reg [1:0]            tx_state;
  reg [1:0]            next_tx_state;
  reg [`UCP_CNT_W-1:0] tx_cnt;
  reg [`UCP_CNT_W-1:0] next_tx_cnt;
  reg                  tx_send;

  wire tx_req   = tx_edge & ~tx_en_n_p;
  wire tx_whole = (txf_level >= {1'b0, `UCP_CELL_BYTES});

  always @* begin
    next_tx_state = tx_state;
    next_tx_cnt   = tx_cnt;
    tx_send       = 1'b0;
    case (tx_state)
      TX_IDLE: begin
        if (tx_req & tx_whole) begin
          tx_send       = 1'b1;
          next_tx_cnt   = `UCP_CELL_BYTES - 4'h1;
          next_tx_state = TX_CELL;
        end
      end
      TX_CELL: begin
        if (tx_req) begin
          if (tx_cnt == 4'h0) begin
            next_tx_state = TX_IDLE;
          end else begin
            tx_send     = 1'b1;
            next_tx_cnt = tx_cnt - 4'h1;
          end
        end
      end
      default: begin
        next_tx_state = TX_IDLE;
      end
    endcase
  end

  assign txf_pop = tx_send & txf_valid;

  always @(posedge clock) begin
    if (rst | ~cell_if_enable) begin
      tx_state           <= TX_IDLE;
      tx_cnt             <= 4'h0;
      tx_cell_byte       <= 8'h00;
      tx_first_byte_mark <= 1'b0;
      tx_cell_avail      <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      tx_cnt   <= next_tx_cnt;
      // outputs change just after a link edge, stable for the next one
      if (tx_send) begin
        tx_cell_byte       <= txf_data;
        tx_first_byte_mark <= (tx_state == TX_IDLE);
      end else if (tx_edge) begin
        tx_first_byte_mark <= 1'b0;
      end
      if (tx_edge) begin
        tx_cell_avail <= (next_tx_state == TX_IDLE) ?
                         (txf_level - {4'h0, txf_pop} >=
                          {1'b0, `UCP_CELL_BYTES}) :
                         (txf_level - {4'h0, txf_pop} >=
                          {1'b0, `UCP_CELL_BYTES} + {1'b0, next_tx_cnt});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive buffer
  reg                   rxf_push;
  reg [`UCP_BYTE_W-1:0] rxf_byte;
  wire                  rxf_ready;
  wire [`UCP_LVL_W-1:0] rxf_level;

  ucp_fifo #(
    .W  (`UCP_BYTE_W),
    .D  (`UCP_FIFO_DEPTH),
    .AW (`UCP_FIFO_AW)
  ) u_rx_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (rxf_push),
    .in_ready  (rxf_ready),
    .in_data   (rxf_byte),
    .out_valid (rx_out_valid),
    .out_ready (rx_out_ready),
    .out_data  (rx_out_data),
    .level     (rxf_level)
  );

  ////////////////////////////////////////////////////////////////////////
  // receive state machine
  localparam RX_IDLE = 2'b01;
  localparam RX_CELL = 2'b10;

  reg [1:0]            rx_state;
  reg [`UCP_CNT_W-1:0] rx_cnt;
  reg                  rx_en_d;
  reg                  rx_mine;

  wire sel_hit  = (rx_sel_p == rx_own_addr);
  // a byte is valid on an edge after one where enable was low
  wire rx_take  = rx_edge & rx_en_d & rx_mine;
  localparam [31:0] RX_DEPTH = `UCP_FIFO_DEPTH;
  wire [`UCP_LVL_W-1:0] rx_free = RX_DEPTH[`UCP_LVL_W-1:0] - rxf_level;
  wire [`UCP_LVL_W-1:0] rx_owed = (rx_state == RX_CELL) ?
                                  {1'b0, rx_cnt} : 5'h00;

  always @(posedge clock) begin
    if (rst | ~cell_if_enable) begin
      rx_state       <= RX_IDLE;
      rx_cnt         <= 4'h0;
      rx_en_d        <= 1'b0;
      rx_mine        <= 1'b0;
      rxf_push       <= 1'b0;
      rxf_byte       <= 8'h00;
      rx_space_avail <= 1'b0;
      rx_overrun     <= 1'b0;
    end else begin
      rxf_push <= 1'b0;
      if (rx_edge) begin
        rx_en_d <= ~rx_en_n_p;
        // selection is taken with the enable, held for the cell
        if (~rx_en_n_p & ~rx_en_d) begin
          rx_mine <= sel_hit;
        end
      end
      if (rx_take) begin
        case (rx_state)
          RX_IDLE: begin
            if (rx_soc_p & rx_space_avail) begin
              rxf_push <= 1'b1;
              rxf_byte <= rx_byte_p;
              rx_cnt   <= `UCP_CELL_BYTES - 4'h1;
              rx_state <= RX_CELL;
            end
          end
          RX_CELL: begin
            rxf_push <= 1'b1;
            rxf_byte <= rx_byte_p;
            rx_cnt   <= rx_cnt - 4'h1;
            if (rx_cnt == 4'h1) begin
              rx_state <= RX_IDLE;
            end
          end
          default: begin
            rx_state <= RX_IDLE;
          end
        endcase
      end
      if (rxf_push & ~rxf_ready) begin
        rx_overrun <= 1'b1;
      end
      // room for a whole cell beyond any bytes still owed
      rx_space_avail <= (rx_free >= rx_owed +
                         {1'b0, `UCP_CELL_BYTES});
    end
  end

  // only the addressed slave drives the shared space flag
  assign rx_space_avail_oe = cell_if_enable &
                             (rx_sel_s == rx_own_addr);

endmodule

/* test/ucp_chk.sv */
// assertion checker on the cell port pins
`timescale 1ns/1ns
module ucp_chk (
  // clock and reset
  input wire       clock,
  input wire       rst,
  // strap and address
  input wire       cell_if_strap,
  input wire       cell_if_enable,
  input wire [2:0] sp_shared_in,
  input wire [4:0] rx_slave_sel,
  input wire [4:0] rx_own_addr,
  // link outputs
  input wire [7:0] tx_cell_byte,
  input wire       tx_cell_byte_oe,
  input wire       tx_first_byte_mark,
  input wire       tx_first_byte_mark_oe,
  input wire       tx_cell_avail,
  input wire       tx_cell_avail_oe,
  input wire       rx_space_avail,
  input wire       rx_space_avail_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_off_no_drive:
    assert property (!cell_if_enable |-> !(tx_cell_byte_oe ||
      tx_first_byte_mark_oe || tx_cell_avail_oe || rx_space_avail_oe))
      else $error("pin driven while port off");
  a_off_zero:
    assert property (!cell_if_enable |-> tx_cell_byte == 8'h00 &&
      !tx_first_byte_mark && !tx_cell_avail && !rx_space_avail)
      else $error("output set while port off");
  a_on_drives:
    assert property (cell_if_enable |-> tx_cell_byte_oe &&
      tx_first_byte_mark_oe && tx_cell_avail_oe)
      else $error("tx pins not driven while on");
  a_shared_zero:
    assert property (cell_if_enable |-> sp_shared_in == 3'h0)
      else $error("shared pins leak while on");
  a_shared_pass:
    assert property ((!cell_if_enable && $stable(rx_slave_sel))[*6]
      |-> sp_shared_in == rx_slave_sel[4:2])
      else $error("shared pins not passed while off");
  a_strap_on:
    assert property ($fell(rst) ##0 cell_if_strap |-> ##[1:4] cell_if_enable)
      else $error("strap high not caught");
  a_strap_off:
    assert property ($fell(rst) ##0 !cell_if_strap |-> !cell_if_enable[*8])
      else $error("port on with strap low");
  a_rx_unselected:
    assert property (($stable(rx_slave_sel) && rx_slave_sel != rx_own_addr)[*4]
      |-> !rx_space_avail_oe)
      else $error("space flag driven when not addressed");
  a_mark_hold:
    assert property ($rose(tx_first_byte_mark) |-> tx_first_byte_mark[*8])
      else $error("tx mark shorter than a link period");
  a_byte_hold:
    assert property ($rose(tx_first_byte_mark) |->
      ##2 $stable(tx_cell_byte)[*6])
      else $error("first tx byte not held");
endmodule
bind ucp_cell_port ucp_chk chk (.clock(clock), .rst(rst),
  .cell_if_strap(cell_if_strap), .cell_if_enable(cell_if_enable),
  .sp_shared_in(sp_shared_in), .rx_slave_sel(rx_slave_sel),
  .rx_own_addr(rx_own_addr), .tx_cell_byte(tx_cell_byte),
  .tx_cell_byte_oe(tx_cell_byte_oe), .tx_cell_avail(tx_cell_avail),
  .tx_first_byte_mark(tx_first_byte_mark), .tx_cell_avail_oe(tx_cell_avail_oe),
  .tx_first_byte_mark_oe(tx_first_byte_mark_oe),
  .rx_space_avail(rx_space_avail), .rx_space_avail_oe(rx_space_avail_oe));

/* test/ucp_master.sv */
// master controller model driving both link directions
`timescale 1ns/1ns
module ucp_master (
  // paces the link clocks
  input wire        clock,
  // transmit link
  output reg        tx_link_clk,
  output reg        tx_xfer_en_n,
  input  wire [7:0] tx_cell_byte,
  input  wire       tx_first_byte_mark,
  input  wire       tx_cell_avail,
  // receive link
  output reg        rx_link_clk,
  output reg        rx_xfer_en_n,
  output reg        rx_first_byte_mark,
  output reg  [7:0] rx_cell_byte,
  output reg  [4:0] rx_slave_sel
);
  reg [7:0] got_byte;
  reg       got_mark;
  reg       got_avail;
  initial begin
    tx_link_clk = 1'b0;
    rx_link_clk = 1'b0;
    tx_xfer_en_n = 1'b1;
    rx_xfer_en_n = 1'b1;
    rx_first_byte_mark = 1'b0;
    rx_cell_byte = 8'h55;
    rx_slave_sel = 5'h14;
  end
  // one link period of 80 ns; slave outputs taken at the rise
  task tick(input rx);
    begin
      @(negedge clock);
      if (rx) rx_link_clk = 1'b1;
      else tx_link_clk = 1'b1;
      got_byte = tx_cell_byte;
      got_mark = tx_first_byte_mark;
      got_avail = tx_cell_avail;
      repeat (5) @(negedge clock);
      rx_link_clk = 1'b0;
      tx_link_clk = 1'b0;
      repeat (4) @(negedge clock);
    end
  endtask
  task wait_avail;
    integer n;
    begin
      got_avail = 1'b0;
      for (n = 0; n < 12 && got_avail !== 1'b1; n = n + 1) tick(1'b0);
    end
  endtask
  task take_cell(output [63:0] bytes, output [7:0] marks);
    integer i;
    begin
      tx_xfer_en_n = 1'b0;
      tick(1'b0);
      for (i = 0; i < 8; i = i + 1) begin
        tick(1'b0);
        bytes[i*8 +: 8] = got_byte;
        marks[i] = got_mark;
      end
      tx_xfer_en_n = 1'b1;
    end
  endtask
  task send_cell(input [4:0] sel, input [7:0] first);
    integer i;
    begin
      rx_slave_sel = sel;
      rx_xfer_en_n = 1'b0;
      tick(1'b1);
      for (i = 0; i < 8; i = i + 1) begin
        rx_first_byte_mark = (i == 0);
        rx_cell_byte = first + i[7:0];
        tick(1'b1);
      end
      rx_xfer_en_n = 1'b1;
      rx_first_byte_mark = 1'b0;
      rx_cell_byte = ~rx_cell_byte;
      tick(1'b1);
    end
  endtask
endmodule

/* test/testbench.sv */
// self-checking bench for the cell port
`timescale 1ns/1ns
module testbench;
  reg        clock;
  reg        rst;
  reg        cell_if_strap;
  reg        tx_in_valid;
  reg  [7:0] tx_in_data;
  reg        rx_out_ready;
  wire       cell_if_enable, tx_in_ready, rx_out_valid, rx_overrun;
  wire [2:0] sp_shared_in;
  wire [7:0] tx_cell_byte, rx_cell_byte, rx_out_data;
  wire [4:0] rx_slave_sel;
  wire       tx_cell_byte_oe, tx_first_byte_mark_oe, tx_cell_avail_oe;
  wire       tx_first_byte_mark, tx_cell_avail, rx_space_avail;
  wire       rx_space_avail_oe, tx_link_clk, tx_xfer_en_n, rx_link_clk;
  wire       rx_xfer_en_n, rx_first_byte_mark;
  integer    miscompares;
  integer    checks_done;
  ucp_cell_port uut (.clock(clock), .rst(rst), .cell_if_strap(cell_if_strap),
    .rx_own_addr(5'h09), .cell_if_enable(cell_if_enable),
    .sp_shared_in(sp_shared_in), .tx_link_clk(tx_link_clk),
    .tx_xfer_en_n(tx_xfer_en_n), .tx_cell_byte(tx_cell_byte),
    .tx_cell_byte_oe(tx_cell_byte_oe), .tx_cell_avail(tx_cell_avail),
    .tx_first_byte_mark(tx_first_byte_mark),
    .tx_cell_avail_oe(tx_cell_avail_oe),
    .tx_first_byte_mark_oe(tx_first_byte_mark_oe), .rx_link_clk(rx_link_clk),
    .rx_xfer_en_n(rx_xfer_en_n), .rx_first_byte_mark(rx_first_byte_mark),
    .rx_cell_byte(rx_cell_byte), .rx_slave_sel(rx_slave_sel),
    .rx_space_avail(rx_space_avail), .rx_space_avail_oe(rx_space_avail_oe),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready),
    .tx_in_data(tx_in_data), .rx_out_valid(rx_out_valid),
    .rx_out_ready(rx_out_ready), .rx_out_data(rx_out_data),
    .rx_overrun(rx_overrun));
  ucp_master m (.clock(clock), .tx_link_clk(tx_link_clk),
    .tx_xfer_en_n(tx_xfer_en_n), .tx_cell_byte(tx_cell_byte),
    .tx_first_byte_mark(tx_first_byte_mark), .tx_cell_avail(tx_cell_avail),
    .rx_link_clk(rx_link_clk), .rx_xfer_en_n(rx_xfer_en_n),
    .rx_first_byte_mark(rx_first_byte_mark), .rx_cell_byte(rx_cell_byte),
    .rx_slave_sel(rx_slave_sel));
  always #4 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task check(input [8*10:1] what, input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  task do_reset(input strap);
    begin
      rst = 1'b1;
      cell_if_strap = strap;
      repeat (6) @(negedge clock);
      rst = 1'b0;
      repeat (8) @(negedge clock);
    end
  endtask
  task push(input [7:0] d);
    integer n;
    begin
      tx_in_valid = 1'b1;
      tx_in_data = d;
      for (n = 0; n < 50 && tx_in_ready !== 1'b1; n = n + 1) @(negedge clock);
      @(negedge clock);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // strap low: pins released, link ignored, shared pins to serial port
  task t_port_off;
    begin
      do_reset(1'b0);
      check("enable", cell_if_enable, 8'h00);
      check("shared", sp_shared_in, 8'h05);
      m.send_cell(5'h09, 8'h40);
      check("oe", {tx_cell_byte_oe, rx_space_avail_oe}, 8'h00);
      check("rx valid", rx_out_valid, 8'h00);
    end
  endtask
  // fill transmit buffer until refused, pull two cells, then empty
  task t_tx;
    integer i, j;
    reg [63:0] bytes;
    reg [7:0]  marks;
    begin
      for (i = 0; i < 16; i = i + 1) push(8'ha0 + i[7:0]);
      tx_in_valid = 1'b0;
      check("tx ready", tx_in_ready, 8'h00);
      for (i = 0; i < 2; i = i + 1) begin
        m.wait_avail;
        check("tx avail", m.got_avail, 8'h01);
        m.take_cell(bytes, marks);
        // a second whole cell stays flagged while the first drains
        check("tx avail", m.got_avail, {7'h00, i == 0});
        check("tx marks", marks, 8'h01);
        for (j = 0; j < 8; j = j + 1)
          check("tx byte", bytes[j*8+:8], 8'ha0 + {i[4:0], j[2:0]});
      end
      m.tick(1'b0);
      m.tick(1'b0);
      check("tx avail", m.got_avail, 8'h00);
    end
  endtask
  // other address ignored, two cells fill the buffer, a third is refused
  task t_rx;
    integer i, n;
    begin
      check("rx space", rx_space_avail, 8'h01);
      m.send_cell(5'h12, 8'h70);
      check("rx sel", {rx_space_avail_oe, rx_out_valid}, 8'h00);
      m.send_cell(5'h09, 8'h30);
      m.send_cell(5'h09, 8'h38);
      check("rx space", {rx_space_avail_oe, rx_space_avail}, 8'h02);
      m.send_cell(5'h09, 8'h80);
      check("overrun", rx_overrun, 8'h00);
      rx_out_ready = 1'b1;
      i = 0;
      for (n = 0; n < 200 && i < 16; n = n + 1) begin
        if (rx_out_valid === 1'b1) begin
          check("rx byte", rx_out_data, 8'h30 + i[7:0]);
          i = i + 1;
        end
        @(negedge clock);
      end
      check("rx count", i[7:0], 8'h10);
      check("rx empty", rx_out_valid, 8'h00);
      check("rx space", rx_space_avail, 8'h01);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    cell_if_strap = 1'b0;
    tx_in_valid = 1'b0;
    tx_in_data = 8'h00;
    rx_out_ready = 1'b0;
    miscompares = 0;
    checks_done = 0;
    @(negedge clock);
    t_port_off;
    do_reset(1'b1);
    check("enable", cell_if_enable, 8'h01);
    check("shared", sp_shared_in, 8'h00);
    t_tx;
    t_rx;
    print_verdict;
  end
  initial begin
    #60000;
    miscompares = miscompares + 1;
    print_verdict;
  end
endmodule
